// File: rtl/chs_pkg.sv
package chs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          CHS_ADDR_W       = 5;       // Register index width
    localparam int          CHS_DATA_W       = 16;      // Register data width
    localparam logic [4:0]  CHS_ADDR_STATUS  = 5'h0f;   // Channel status word
    localparam logic [4:0]  CHS_ADDR_TALLY   = 5'h10;   // Line error tally
    localparam logic [15:0] CHS_STATUS_RESET = 16'h0000; // Status word after reset
    localparam logic [15:0] CHS_TALLY_RESET  = 16'hfffd; // Tally after reset
    localparam logic [15:0] CHS_UNMAPPED     = 16'h0000; // Answer to any other index

    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int CHS_BIT_PATTERN  = 15;  // Pattern checker aligned
    localparam int CHS_BIT_LANE     = 14;  // Lane alignment follower ok
    localparam int CHS_BIT_LOS      = 13;  // Line signal lost
    localparam int CHS_BIT_AUTOZERO = 12;  // Auto-zero done
    localparam int CHS_BIT_GAIN     = 11;  // Gain loop locked
    localparam int CHS_BIT_SYNC     = 10;  // Line sync achieved
    localparam int CHS_BIT_RSVD     = 9;   // Reserved, reads zero
    localparam int CHS_BIT_BADCW    = 8;   // Bad code word seen
    localparam int CHS_BIT_TXU      = 7;   // Transmit FIFO underflow
    localparam int CHS_BIT_TXO      = 6;   // Transmit FIFO overflow
    localparam int CHS_BIT_RXU      = 5;   // Receive FIFO underflow
    localparam int CHS_BIT_RXO      = 4;   // Receive FIFO overflow
    localparam int CHS_BIT_RXLINK   = 3;   // Client receive link good
    localparam int CHS_BIT_TXLINK   = 2;   // Client training link good
    localparam int CHS_BIT_CPLL     = 1;   // Client PLL locked
    localparam int CHS_BIT_LPLL     = 0;   // Line PLL locked

    localparam int CHS_NUM_LL = 8;         // Latched-low bits
    localparam int CHS_NUM_LH = 6;         // Latched-high bits

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Live condition levels from the datapath
    typedef struct packed {
        logic line_pattern_aligned;
        logic lane_align_follower_ok;
        logic line_autozero_done;
        logic line_gain_loop_locked;
        logic line_sync_achieved;
        logic client_receive_link_good;
        logic client_training_link_good;
        logic client_pll_locked;
        logic line_pll_locked;
    } chs_live_t;

    // Events that latch high (levels or pulses)
    typedef struct packed {
        logic line_signal_lost;
        logic line_bad_codeword;
        logic tx_fifo_underflow;
        logic tx_fifo_overflow;
        logic rx_fifo_underflow;
        logic rx_fifo_overflow;
    } chs_event_t;

    // One-cycle error pulses feeding the tally
    typedef struct packed {
        logic decode_err;
        logic pattern_err;
        logic prbs_err;
    } chs_err_t;

endpackage

// File: rtl/chs_status_bank.sv
`timescale 1ns/100ps
module chs_status_bank
#(
    parameter int CNT_WIDTH = 16               // Tally width
)
(
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Register read port from the management frame engine
    input  wire logic                     rd_en,
    input  wire logic [chs_pkg::CHS_ADDR_W-1:0] rd_addr,
    output logic [chs_pkg::CHS_DATA_W-1:0] rd_data_ff,
    output logic                          rd_valid_ff,
    // Datapath conditions
    input  wire chs_pkg::chs_live_t       live,
    input  wire chs_pkg::chs_event_t      ev,
    input  wire chs_pkg::chs_err_t        err,
    // Mode controls
    input  wire logic                     decoder_enable,
    input  wire logic                     random_jitter_pattern,
    input  wire logic                     test_pattern_mode,
    input  wire logic                     pseudo_random_check_pin
);
    import chs_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // Tally must fit the register and allow an increment
    if (CNT_WIDTH < 2 || CNT_WIDTH > CHS_DATA_W)
    begin : g_bad_width
        $error("CNT_WIDTH must be 2 to 16");
    end

    localparam logic [CNT_WIDTH-1:0] TALLY_MAX = {CNT_WIDTH{1'b1}};      // Saturation
    localparam logic [CNT_WIDTH-1:0] TALLY_ONE = {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    localparam logic [CNT_WIDTH-1:0] TALLY_RST = CHS_TALLY_RESET[CNT_WIDTH-1:0];

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                  status_read;     // Read of the status word
    logic                  tally_read;      // Read of the tally
    logic [CHS_NUM_LL-1:0] ll_src;          // Live latched-low sources
    logic [CHS_NUM_LH-1:0] lh_src;          // Latched-high event sources
    logic [CHS_NUM_LL-1:0] ll_ff;           // Latched-low storage
    logic [CHS_NUM_LL-1:0] nxt_ll;
    logic [CHS_NUM_LH-1:0] lh_ff;           // Latched-high storage
    logic [CHS_NUM_LH-1:0] nxt_lh;
    logic                  pattern_ff;      // Pattern aligned, plain read-only
    logic                  nxt_pattern;
    logic [CNT_WIDTH-1:0]  tally_ff;        // Line error tally
    logic [CNT_WIDTH-1:0]  nxt_tally;
    logic                  tally_inc;       // Selected error source fired
    logic [15:0]           status_word;     // Assembled status view
    logic [15:0]           tally_word;      // Tally widened to the register
    logic [15:0]           nxt_rd_data;
    logic                  nxt_rd_valid;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    // Reads are side-effecting, so decode them once here
    always_comb
    begin
        status_read = rd_en && (rd_addr == CHS_ADDR_STATUS);
        tally_read  = rd_en && (rd_addr == CHS_ADDR_TALLY);
    end

    // ------------------------------------------------------------
    // Source vectors
    // ------------------------------------------------------------
    // Gather conditions so one loop handles each latch kind
    always_comb
    begin
        ll_src[7] = live.lane_align_follower_ok;
        ll_src[6] = live.line_autozero_done;
        ll_src[5] = live.line_gain_loop_locked;
        ll_src[4] = live.line_sync_achieved;
        ll_src[3] = live.client_receive_link_good;
        ll_src[2] = live.client_training_link_good;
        ll_src[1] = live.client_pll_locked;
        ll_src[0] = live.line_pll_locked;
        lh_src[5] = ev.line_signal_lost;
        // Decode faults only mean something with a decoder in the path
        lh_src[4] = ev.line_bad_codeword && (decoder_enable || random_jitter_pattern);
        lh_src[3] = ev.tx_fifo_underflow;
        lh_src[2] = ev.tx_fifo_overflow;
        lh_src[1] = ev.rx_fifo_underflow;
        lh_src[0] = ev.rx_fifo_overflow;
    end

    // ------------------------------------------------------------
    // Latched bit next state
    // ------------------------------------------------------------
    // Latched-low: a drop sticks until read, read reloads the live level
    for (genvar i = 0; i < CHS_NUM_LL; i++)
    begin : g_ll
        always_comb
        begin
            if (status_read)
            begin
                nxt_ll[i] = ll_src[i];
            end
            else
            begin
                nxt_ll[i] = ll_ff[i] & ll_src[i];
            end
        end
    end

    // Latched-high: event wins over a clearing read in the same cycle
    for (genvar j = 0; j < CHS_NUM_LH; j++)
    begin : g_lh
        always_comb
        begin
            nxt_lh[j] = lh_src[j] | (lh_ff[j] & ~status_read);
        end
    end

    // Pattern bit is not latched, it just tracks the checker
    always_comb
    begin
        nxt_pattern = live.line_pattern_aligned;
    end

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ll_ff      <= '0;
            lh_ff      <= '0;
            pattern_ff <= 1'b0;
        end
        else
        begin
            ll_ff      <= nxt_ll;
            lh_ff      <= nxt_lh;
            pattern_ff <= nxt_pattern;
        end
    end

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    always_comb
    begin
        status_word                   = CHS_STATUS_RESET;
        status_word[CHS_BIT_PATTERN]  = pattern_ff;
        status_word[CHS_BIT_LANE]     = ll_ff[7];
        status_word[CHS_BIT_LOS]      = lh_ff[5];
        status_word[CHS_BIT_AUTOZERO] = ll_ff[6];
        status_word[CHS_BIT_GAIN]     = ll_ff[5];
        status_word[CHS_BIT_SYNC]     = ll_ff[4];
        status_word[CHS_BIT_RSVD]     = 1'b0;         // Reserved
        status_word[CHS_BIT_BADCW]    = lh_ff[4];
        status_word[CHS_BIT_TXU]      = lh_ff[3];
        status_word[CHS_BIT_TXO]      = lh_ff[2];
        status_word[CHS_BIT_RXU]      = lh_ff[1];
        status_word[CHS_BIT_RXO]      = lh_ff[0];
        status_word[CHS_BIT_RXLINK]   = ll_ff[3];
        status_word[CHS_BIT_TXLINK]   = ll_ff[2];
        status_word[CHS_BIT_CPLL]     = ll_ff[1];
        status_word[CHS_BIT_LPLL]     = ll_ff[0];
    end

    // ------------------------------------------------------------
    // Error tally
    // ------------------------------------------------------------
    // PRBS pin beats pattern mode, which beats functional counting
    always_comb
    begin
        if (pseudo_random_check_pin)
        begin
            tally_inc = err.prbs_err;
        end
        else if (test_pattern_mode)
        begin
            tally_inc = err.pattern_err;
        end
        else
        begin
            tally_inc = err.decode_err;
        end
    end

    // Saturate so a long soak never wraps to a small count
    always_comb
    begin
        if (tally_read)
        begin
            // An error in the read cycle is kept, not lost
            nxt_tally = tally_inc ? TALLY_ONE : '0;
        end
        else if (tally_inc && (tally_ff != TALLY_MAX))
        begin
            nxt_tally = tally_ff + TALLY_ONE;
        end
        else
        begin
            nxt_tally = tally_ff;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tally_ff <= TALLY_RST;
        end
        else
        begin
            tally_ff <= nxt_tally;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    // Answer the cycle after the read, showing pre-clear contents
    always_comb
    begin
        tally_word                = '0;
        tally_word[CNT_WIDTH-1:0] = tally_ff;
        nxt_rd_valid              = rd_en;
        nxt_rd_data               = rd_data_ff;
        if (status_read)
        begin
            nxt_rd_data = status_word;
        end
        else if (tally_read)
        begin
            nxt_rd_data = tally_word;
        end
        else if (rd_en)
        begin
            nxt_rd_data = CHS_UNMAPPED;               // Unmapped index
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
        end
        else
        begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_pattern_follow: assert property (
        live.line_pattern_aligned |=> status_word[CHS_BIT_PATTERN])
        else $error("pattern bit missed alignment");
    chk_los_latch: assert property (
        ev.line_signal_lost |=> status_word[CHS_BIT_LOS])
        else $error("signal lost not latched");
    chk_los_hold: assert property (
        status_word[CHS_BIT_LOS] && !status_read |=> status_word[CHS_BIT_LOS])
        else $error("latched-high bit dropped before read");
    chk_badcw_gate: assert property (
        ev.line_bad_codeword && !decoder_enable && !random_jitter_pattern && !status_read
        && !status_word[CHS_BIT_BADCW] |=> !status_word[CHS_BIT_BADCW])
        else $error("bad code word latched while decoder off");
    chk_txfifo_flags: assert property (
        (ev.tx_fifo_underflow |=> status_word[CHS_BIT_TXU])
        and (ev.tx_fifo_overflow |=> status_word[CHS_BIT_TXO]))
        else $error("tx fifo flag not latched");
    chk_rxfifo_flags: assert property (
        (ev.rx_fifo_underflow |=> status_word[CHS_BIT_RXU])
        and (ev.rx_fifo_overflow |=> status_word[CHS_BIT_RXO]))
        else $error("rx fifo flag not latched");
    chk_pll_drop: assert property (
        !live.line_pll_locked |=> !status_word[CHS_BIT_LPLL])
        else $error("line pll drop not seen");
    chk_sync_stick: assert property (
        !status_word[CHS_BIT_SYNC] && !status_read |=> !status_word[CHS_BIT_SYNC])
        else $error("latched-low bit rose without read");
    chk_tally_return: assert property (
        tally_read |=> rd_valid_ff && rd_data_ff[CNT_WIDTH-1:0] == $past(tally_ff))
        else $error("tally read returned wrong value");
    chk_tally_clear: assert property (
        tally_read && !tally_inc |=> tally_ff == '0)
        else $error("tally not cleared by read");
    chk_tally_count: assert property (
        !pseudo_random_check_pin && !test_pattern_mode && err.decode_err && !tally_read
        && tally_ff != TALLY_MAX |=> tally_ff == $past(tally_ff) + TALLY_ONE)
        else $error("decode error not counted");
    chk_prbs_select: assert property (
        pseudo_random_check_pin && !err.prbs_err && !tally_read |=> $stable(tally_ff))
        else $error("tally moved without prbs error");

endmodule

// File: test/chs_host_model.sv
`timescale 1ns/100ps
module chs_host_model
(
    input  wire logic                           clk,
    input  wire logic                           reset,
    output logic                                rd_en,
    output logic [chs_pkg::CHS_ADDR_W-1:0]      rd_addr,
    input  wire logic [chs_pkg::CHS_DATA_W-1:0] rd_data_ff,
    input  wire logic                           rd_valid_ff
);
    import chs_pkg::*;

    // ------------------------------------------------------------
    // Management host reader
    // ------------------------------------------------------------
    // Idle port at time zero
    initial
    begin
        rd_en   = 1'b0;
        rd_addr = '0;
    end

    // One read; gap idle cycles first model a slow host
    task automatic read(input logic [CHS_ADDR_W-1:0] a, input int gap,
                        output logic [CHS_DATA_W-1:0] d, output logic v);
        // No request while the block is held in reset
        while (reset) @(posedge clk);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        rd_en   <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en   <= 1'b0;
        // Released index shows the inverse, never a stale match
        rd_addr <= ~a;
        // Answer register settles after the taking edge
        #1;
        d = rd_data_ff;
        v = rd_valid_ff;
    endtask
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
    import chs_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                  clk;
    logic                  reset;
    logic                  rd_en;
    logic [CHS_ADDR_W-1:0] rd_addr;
    logic [CHS_DATA_W-1:0] rd_data_ff;
    logic                  rd_valid_ff;
    chs_live_t             live;
    chs_event_t            ev;
    chs_err_t              err;
    logic                  decoder_enable;
    logic                  random_jitter_pattern;
    logic                  test_pattern_mode;
    logic                  pseudo_random_check_pin;
    int                    error_cnt;
    int                    compares;
    logic [15:0]           full;   // Word with every live level high
    // Status positions of live bits 0..7 and event bits 0..5
    localparam int LL_POS [8] = '{CHS_BIT_LPLL, CHS_BIT_CPLL, CHS_BIT_TXLINK, CHS_BIT_RXLINK,
                                  CHS_BIT_SYNC, CHS_BIT_GAIN, CHS_BIT_AUTOZERO, CHS_BIT_LANE};
    localparam int LH_POS [6] = '{CHS_BIT_RXO, CHS_BIT_RXU, CHS_BIT_TXO, CHS_BIT_TXU,
                                  CHS_BIT_BADCW, CHS_BIT_LOS};

    // ------------------------------------------------------------
    // Design and host
    // ------------------------------------------------------------
    chs_status_bank i_chs_status_bank
    (
        .clk(clk), .reset(reset), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .live(live), .ev(ev),
        .err(err), .decoder_enable(decoder_enable),
        .random_jitter_pattern(random_jitter_pattern),
        .test_pattern_mode(test_pattern_mode),
        .pseudo_random_check_pin(pseudo_random_check_pin)
    );

    chs_host_model i_chs_host_model
    (
        .clk(clk), .reset(reset), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Read and compare; answer valid must stand in the next cycle
    task automatic rd(input string nm, input logic [4:0] a, input logic [15:0] exp, input int gap);
        logic [15:0] d;
        logic        v;
        i_chs_host_model.read(a, gap, d, v);
        check({nm, " valid"}, {15'h0, v}, 16'h0001);
        check(nm, d, exp);
    endtask

    // One-cycle pulses, a free cycle after each
    task automatic pulse_err(input chs_err_t v);
        @(posedge clk) err <= v;
        @(posedge clk) err <= '0;
    endtask

    task automatic pulse_ev(input int i);
        @(posedge clk) ev[i] <= 1'b1;
        @(posedge clk) ev[i] <= 1'b0;
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog: the tests need well under 2000 cycles
    initial
    begin
        #(50 * 20000);
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        error_cnt = 0;
        compares = 0;
        reset = 1'b1;
        live = '0;
        ev = '0;
        err = '0;
        decoder_enable = 1'b1;
        random_jitter_pattern = 1'b0;
        test_pattern_mode = 1'b0;
        pseudo_random_check_pin = 1'b0;
        full = 16'h1 << CHS_BIT_PATTERN;
        for (int i = 0; i < 8; i++)
            full = full | (16'h1 << LL_POS[i]);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // Reset values, clear on read, unmapped index
        rd("status reset", CHS_ADDR_STATUS, CHS_STATUS_RESET, 0);
        rd("tally reset", CHS_ADDR_TALLY, CHS_TALLY_RESET, 0);
        rd("tally cleared", CHS_ADDR_TALLY, 16'h0000, 2);
        rd("unmapped", 5'h11, CHS_UNMAPPED, 0);
        $display("test reset values done");
        // Latched-low bits wait for a read before following live levels
        @(posedge clk) live <= '1;
        rd("pattern only", CHS_ADDR_STATUS, 16'h1 << CHS_BIT_PATTERN, 0);
        rd("all live", CHS_ADDR_STATUS, full, 1);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk) live[i] <= 1'b0;
            @(posedge clk) live[i] <= 1'b1;
            rd("low held", CHS_ADDR_STATUS, full & ~(16'h1 << LL_POS[i]), 0);
            rd("low reload", CHS_ADDR_STATUS, full, 0);
        end
        // Pattern bit follows alignment with no latch
        @(posedge clk) live.line_pattern_aligned <= 1'b0;
        rd("pattern lost", CHS_ADDR_STATUS, full & ~(16'h1 << CHS_BIT_PATTERN), 0);
        @(posedge clk) live.line_pattern_aligned <= 1'b1;
        rd("pattern back", CHS_ADDR_STATUS, full, 0);
        $display("test latched low done");
        // Each latched-high event holds until one read
        for (int i = 0; i < 6; i++)
        begin
            pulse_ev(i);
            rd("high held", CHS_ADDR_STATUS, full | (16'h1 << LH_POS[i]), 3);
            rd("high cleared", CHS_ADDR_STATUS, full, 0);
        end
        // Bad code word latches only with decoder or jitter pattern check
        @(posedge clk) decoder_enable <= 1'b0;
        pulse_ev(4);
        rd("codeword gated", CHS_ADDR_STATUS, full, 0);
        @(posedge clk) random_jitter_pattern <= 1'b1;
        pulse_ev(4);
        rd("codeword jitter", CHS_ADDR_STATUS, full | (16'h1 << CHS_BIT_BADCW), 0);
        rd("codeword clear", CHS_ADDR_STATUS, full, 0);
        $display("test latched high done");
        // Tally source per mode: functional, pattern, PRBS pin over pattern
        for (int m = 0; m < 3; m++)
        begin
            @(posedge clk);
            test_pattern_mode <= (m != 0);
            pseudo_random_check_pin <= (m == 2);
            pulse_err('1);
            pulse_err('1);
            pulse_err(~(3'h4 >> m));
            pulse_err(3'h4 >> m);
            rd("tally count", CHS_ADDR_TALLY, 16'h0003, 0);
            rd("tally zero", CHS_ADDR_TALLY, 16'h0000, 0);
        end
        $display("test tally modes done");
        // Mid-run reset, then count up from the reset value into saturation
        @(posedge clk) reset <= 1'b1;
        live <= '0;
        test_pattern_mode <= 1'b0;
        pseudo_random_check_pin <= 1'b0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd("status reset again", CHS_ADDR_STATUS, CHS_STATUS_RESET, 0);
        for (int k = 0; k < 3; k++)
            pulse_err(3'h4);
        rd("tally saturated", CHS_ADDR_TALLY, 16'hffff, 0);
        rd("tally zero again", CHS_ADDR_TALLY, 16'h0000, 0);
        $display("test mid reset done");
        print_verdict();
    end
endmodule
